/* alrt_limit_track.sv */
// Alert limit, hysteresis and lowest-result tracking registers
`timescale 1ns/1ps
`default_nettype none
module alrt_limit_track (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   clkEn,
	input  wire alrt_pkg::alrt_regwr_s  regWr,
	input  wire logic [7:0]             rdPtr,
	output logic [15:0]                 rdData,
	output logic                        rdHit,
	input  wire alrt_pkg::alrt_result_s result,
	input  wire alrt_pkg::alrt_cfg_s    cfg,
	output logic                        underAlert,
	output logic                        overAlert
);
	import alrt_pkg::*;

	logic [RES_W-1:0] underQ, overQ, hystQ, lowestQ;
	logic             underAlertQ, overAlertQ;
	logic [15:0]      rdDataQ;
	logic             rdHitQ;

	// Write decode; pointer comes from the protocol engine
	wire wrUnder  = regWr.wrEn && regWr.ptr == ADDR_UNDER;
	wire wrOver   = regWr.wrEn && regWr.ptr == ADDR_OVER;
	wire wrHyst   = regWr.wrEn && regWr.ptr == ADDR_HYST;
	wire wrLowest = regWr.wrEn && regWr.ptr == ADDR_LOWEST;
	wire [RES_W-1:0] wrField = regWr.wrData[FIELD_MSB:FIELD_LSB];

	// Comparisons, widened by one bit so the sum cannot wrap; the difference is used only when overW > hystW
	wire [RES_W:0] res     = {1'b0, result.value};
	wire [RES_W:0] underW  = {1'b0, underQ};
	wire [RES_W:0] overW   = {1'b0, overQ};
	wire [RES_W:0] hystW   = {1'b0, hystQ};
	wire [RES_W:0] underHi = underW + hystW;
	wire           isBelow = res < underW;
	wire           isAbove = res > overW;
	wire           underOk = res > underHi;
	wire           overOk  = (overW > hystW) && (res < overW - hystW);
	wire           autoMode = cfg.cycleTime != 3'h0;
	wire           newLow   = result.value < lowestQ;

	// Next alert states, evaluated once per completed result
	wire underAlertD = isBelow ? 1'b1 :
		(underAlertQ && (cfg.alertHold || !underOk));
	wire overAlertD  = isAbove ? 1'b1 :
		(overAlertQ && (cfg.alertHold || !overOk));

	// Read mux with reserved bits as zero
	logic [RES_W-1:0] rdField;
	logic             rdSel;
	always_comb begin
		rdSel   = 1'b1;
		rdField = '0;
		case (rdPtr)
			ADDR_UNDER:  rdField = underQ;
			ADDR_OVER:   rdField = overQ;
			ADDR_HYST:   rdField = hystQ;
			ADDR_LOWEST: rdField = lowestQ;
			default:     rdSel   = 1'b0;
		endcase
	end

	// Limit and hysteresis registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			underQ <= RST_UNDER[FIELD_MSB:FIELD_LSB];
			overQ  <= RST_OVER[FIELD_MSB:FIELD_LSB];
			hystQ  <= RST_HYST[FIELD_MSB:FIELD_LSB];
		end else if (clkEn) begin
			if (wrUnder) underQ <= wrField;
			if (wrOver)  overQ  <= wrField;
			if (wrHyst)  hystQ  <= wrField;
		end
	end

	// Lowest result; a software write takes priority over tracking
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lowestQ <= RST_LOWEST[FIELD_MSB:FIELD_LSB];
		end else if (clkEn) begin
			if (wrLowest) begin
				lowestQ <= wrField;
			end else if (result.valid && autoMode && newLow) begin
				lowestQ <= result.value;
			end
		end
	end

	// Alert flags, updated only on a completed result
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			underAlertQ <= 1'b0;
			overAlertQ  <= 1'b0;
		end else if (clkEn && result.valid) begin
			underAlertQ <= underAlertD;
			overAlertQ  <= overAlertD;
		end
	end

	// Registered read data
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdDataQ <= 16'h0000;
			rdHitQ  <= 1'b0;
		end else if (clkEn) begin
			rdDataQ <= {4'h0, rdField, 2'h0};
			rdHitQ  <= rdSel;
		end
	end

	assign rdData     = rdDataQ;
	assign rdHit      = rdHitQ;
	assign underAlert = underAlertQ;
	assign overAlert  = overAlertQ;
endmodule
`default_nettype wire

/* alrt_pkg.sv */
// Package for the alert limit and lowest-result tracking block
// Notes on behaviour
// - Under-range limit register at pointer 0x03, resets zero, limit in bits 11:2.
// - Raise under-range alert when a result is below the under-range limit.
// - Over-range limit register at pointer 0x04, resets 0x0fff, limit in bits 11:2.
// - Raise over-range alert when a result is above the over-range limit.
// - Hysteresis register at pointer 0x05, resets zero, value in bits 11:2.
// - An alert clears only when a result is inside its limit by more than hysteresis.
// - With alert hold set, alerts stay asserted and never self-clear.
// - Lowest-result register at pointer 0x06, resets 0x0fff, minimum in bits 11:2.
// - Each new result replaces the stored lowest result only when lower.
// - Writing 0x0fff to the lowest-result register restarts tracking from there.
// - Lowest result updates only in automatic conversion mode, never in normal mode.
// - Bits 15:12 and 1:0 read as zero; master writes zeros there. The bench writes 0x0fff to 0x06, with ones in bits 1:0.
// - Automatic mode runs only while the three-bit cycle-time field is non-zero.
package alrt_pkg;
	localparam logic [7:0]  ADDR_UNDER    = 8'h03;
	localparam logic [7:0]  ADDR_OVER     = 8'h04;
	localparam logic [7:0]  ADDR_HYST     = 8'h05;
	localparam logic [7:0]  ADDR_LOWEST   = 8'h06;
	localparam logic [15:0] RST_UNDER     = 16'h0000;
	localparam logic [15:0] RST_OVER      = 16'h0fff;
	localparam logic [15:0] RST_HYST      = 16'h0000;
	localparam logic [15:0] RST_LOWEST    = 16'h0fff;
	localparam int          FIELD_LSB     = 2;
	localparam int          FIELD_MSB     = 11;
	localparam int          RES_W         = 10;

	// Register access from the bus protocol engine
	typedef struct packed {
		logic        wrEn;
		logic [7:0]  ptr;
		logic [15:0] wrData;
	} alrt_regwr_s;

	// Result from the converter and configuration settings
	typedef struct packed {
		logic             valid;
		logic [RES_W-1:0] value;
	} alrt_result_s;

	typedef struct packed {
		logic [2:0] cycleTime;
		logic       alertHold;
	} alrt_cfg_s;
endpackage

/* alrt_limit_track_props.sv */
// Port checks for the alert limit block
`timescale 1ns/1ps
`default_nettype none
module alrt_limit_track_props (input wire logic core_clk, rst, clkEn, rdHit, underAlert,
	input wire logic overAlert, input wire logic [7:0] rdPtr, input wire logic [15:0] rdData,
	input wire alrt_pkg::alrt_regwr_s regWr, input wire alrt_pkg::alrt_result_s result,
	input wire alrt_pkg::alrt_cfg_s cfg);
	wire logic ev = clkEn && result.valid;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	rsvd_rd_a: assert property (!{rdData[15:12], rdData[1:0]}) else $error("rsvd");
	bad_ptr_a: assert property (clkEn && !(rdPtr inside {[3:6]}) |=> !{rdHit, rdData})
		else $error("ptr");
	ptr_hit_a: assert property (clkEn && rdPtr inside {[3:6]} |=> rdHit) else $error("hit");
	under_set_a: assert property ($rose(underAlert) |-> $past(result.value) != 10'h3ff)
		else $error("lo");
	over_set_a: assert property ($rose(overAlert) |-> $past(result.value) != 10'h0)
		else $error("hi");
	hold_lo_a: assert property (ev && cfg.alertHold && underAlert |=> underAlert)
		else $error("hold");
	hold_hi_a: assert property (ev && cfg.alertHold && overAlert |=> overAlert)
		else $error("hold");
	alert_quiet_a: assert property (!ev |=> $stable({underAlert, overAlert}))
		else $error("quiet");
	cover property (ev && underAlert);
	cover property (ev && cfg.alertHold);
	cover property (rdHit && rdData == 16'h0ffc);
endmodule
bind alrt_limit_track alrt_limit_track_props props (.*);
`default_nettype wire

/* alrt_host_model.sv */
// Register bus master model
`timescale 1ns/1ps
`default_nettype none
module alrt_host_model (input wire logic core_clk, input wire logic [15:0] rdData,
	output var alrt_pkg::alrt_regwr_s regWr, output logic [7:0] rdPtr);
	initial begin regWr = '0; rdPtr = 8'h00; end
	// Pointer and word in one strobe, then released
	task wr(logic [7:0] p, logic [15:0] v); @(negedge core_clk) regWr = '{1'b1, p, v};
		@(negedge core_clk) regWr = '{1'b0, ~p, ~v}; endtask
	// Data taken one edge after the pointer
	task rd(logic [7:0] p, output logic [15:0] v); @(negedge core_clk) rdPtr = p;
		@(negedge core_clk) v = rdData; endtask
endmodule
`default_nettype wire

/* alrt_limit_track_tb_top.sv */
// Bench for the alert limit block
`timescale 1ns/1ps
`default_nettype none
module alrt_limit_track_tb_top;
	import alrt_pkg::*;
	logic core_clk, rst, clkEn, rdHit, underAlert, overAlert;
	logic [7:0] rdPtr;
	logic [15:0] rdData, d;
	alrt_regwr_s regWr;
	alrt_result_s result;
	alrt_cfg_s cfg;
	int fails, cmp_count;
	alrt_limit_track dut (.*);
	alrt_host_model hm (.*);
	task chk(string n, logic [15:0] s, e); cmp_count++;
		if (s !== e) begin fails++; $display("[ERR] %s exp %h got %h", n, e, s); end endtask
	task rc(logic [7:0] p, logic [15:0] e); hm.rd(p, d); chk("rdData", d, e);
		chk("rdHit", {15'h0, rdHit}, {15'h0, p >= ADDR_UNDER && p <= ADDR_LOWEST}); endtask
	// Result pulse, alerts checked after it lands
	task rs(logic [9:0] v, logic [1:0] a); @(negedge core_clk) result = '{1'b1, v};
		@(negedge core_clk) result = '{1'b0, ~v};
		chk("alerts", {underAlert, overAlert}, a); endtask
	task t_rst; for (int i = 3; i < 8; i++) rc(8'(i), i % 2 ? 16'h0 : 16'h0ffc);
		$display("reset done"); endtask
	task t_alert; hm.wr(8'h03, 16'h0100); hm.wr(8'h05, 16'h0020); hm.wr(8'h04, 16'h0200);
		rc(8'h03, 16'h0100); rs(10'd60, 2'b10); rs(10'd72, 2'b10);
		rs(10'd73, 2'b00); rs(10'd129, 2'b01); cfg.alertHold = 1'b1;
		rs(10'd100, 2'b01); $display("alert done"); endtask
	task t_min; cfg = '0; rs(10'd10, 2'b10); rc(8'h06, 16'h0ffc);
		cfg.cycleTime = 3'h7; rs(10'd100, 2'b00); rs(10'd200, 2'b01);
		rc(8'h06, 16'h0190); hm.wr(8'h06, 16'h0fff); rs(10'd120, 2'b01);
		rc(8'h06, 16'h01e0); $display("lowest done"); endtask
	task test_done; $display("checks %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish; endtask
	initial begin core_clk = 1'b0; forever #4 core_clk = ~core_clk; end
	initial begin rst = 1'b1; clkEn = 1'b1; result = '0; cfg = '0; fails = 0; cmp_count = 0;
		repeat (3) @(negedge core_clk); rst = 1'b0; t_rst; t_alert; t_min; test_done; end
endmodule
`default_nettype wire
